// ===== src/acs_pkg.sv
// Shared constants, types and helpers for the conversion sequencer
package acs_pkg;

	localparam int SYS_PERIOD_NS = 5;
	localparam int SYS_CLK_KHZ = 200000;
	localparam int OSC_START_NS = 1000000;
	localparam int OSC_START_CYC = (OSC_START_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int INT_OSC_KHZ = 4920;
	localparam int INT_DIV_HALF = SYS_CLK_KHZ / (2 * INT_OSC_KHZ);
	localparam int SETTLE_PERIODS = 4;
	localparam int ONES_FOR_RESET = 40;

	localparam logic [7:0] CMD_CONT_READ_ENTER = 8'h5c;
	localparam logic [7:0] CMD_DATA_READ = 8'h58;

	localparam logic [2:0] MODE_CONT = 3'h0;
	localparam logic [2:0] MODE_SINGLE = 3'h1;

	localparam logic [1:0] CLKSEL_XTAL = 2'h0;
	localparam logic [1:0] CLKSEL_EXT = 2'h1;
	localparam logic [1:0] CLKSEL_INT = 2'h2;
	localparam logic [1:0] CLKSEL_INT_OUT = 2'h3;

	localparam int DATA_BITS = 24;
	localparam int STATUS_BITS = 8;
	localparam int WORD_BITS = DATA_BITS + STATUS_BITS;
	localparam int STAT_PARITY_POS = 4;
	localparam logic [5:0] LEN_DATA = 6'h18;
	localparam logic [5:0] LEN_DATA_STATUS = 6'h20;
	localparam logic [7:0] CHAN_EN_RESET = 8'h01;

	typedef enum logic [2:0] {
		ACS_IDLE = 3'b001,
		ACS_WAKE = 3'b010,
		ACS_CONV = 3'b100
	} acs_state_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
		logic sync_n;
		logic xtal;
		logic ext_clk;
	} acs_pins_t;

	// Idle pin levels: deselected, serial clock high, sync released
	localparam acs_pins_t PINS_IDLE = 6'h34;

	typedef struct packed {
		logic [DATA_BITS-1:0] data;
		logic [2:0] chan;
		logic parity;
	} acs_result_t;

	// Next enabled channel after cur; bit 3 set when the search wrapped
	function automatic logic [3:0] acs_next_chan(input logic [7:0] en, input logic [2:0] cur);
		logic [3:0] r;
		logic found;
		logic [2:0] i;
		r = {1'b0, cur};
		found = 1'b0;
		for (int k = 1; k <= 8; k++) begin
			i = cur + 3'(k);
			if (!found && en[i]) begin
				r = {(i <= cur), i};
				found = 1'b1;
			end
		end
		return r;
	endfunction

endpackage

// ===== src/acs_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module acs_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] stage1;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stage1 <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

// ===== src/acs_shifter.sv
// Output shift register for conversion words
`timescale 1ns/100ps
`default_nettype none
module acs_shifter
	import acs_pkg::*;
#(
	parameter int W = WORD_BITS
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic load_in,
	input wire logic clear_in,
	input wire logic [W-1:0] word_in,
	input wire logic [5:0] len_in,
	input wire logic sclk_rise_in,
	input wire logic sclk_fall_in,
	output logic bit_out,
	output logic busy_out,
	output logic done_out
);
	logic [W-1:0] sr, next_sr;
	logic [5:0] cnt, next_cnt;
	logic [5:0] len, next_len;
	logic next_busy, next_done;

	always_comb begin
		next_sr = sr;
		next_cnt = cnt;
		next_len = len;
		next_busy = busy_out;
		next_done = 1'b0;
		if (clear_in) begin
			next_busy = 1'b0;
		end else if (load_in) begin
			next_sr = word_in;
			next_cnt = len_in;
			next_len = len_in;
			next_busy = 1'b1;
		end else if (busy_out) begin
			// Shift only after the host has taken a bit
			if (sclk_fall_in && cnt != len) begin
				next_sr = {sr[W-2:0], 1'b0};
			end
			if (sclk_rise_in) begin
				next_cnt = cnt - 6'h1;
				if (cnt == 6'h1) begin
					next_busy = 1'b0;
					next_done = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sr <= '0;
			cnt <= 6'h0;
			len <= 6'h0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end else begin
			sr <= next_sr;
			cnt <= next_cnt;
			len <= next_len;
			busy_out <= next_busy;
			done_out <= next_done;
		end
	end

	assign bit_out = sr[W-1];
endmodule
`default_nettype wire

// ===== src/acs_seq.sv
// Conversion mode sequencer with serial data-ready and output control
// What this block does
// - Mode code single starts power-up, one conversion pass, then power-down.
// - Single conversion waits about 1 ms for oscillator start first.
// - Ready falls at completion, rises after read, stays high until next.
// - Outside continuous read the held result can be read again.
// - Single mode converts each enabled channel once, then powers down.
// - Ready high before each conversion result, low when valid, next begins.
// - Append-status adds status byte; low three bits give channel.
// - Continuous conversion after reset; ready clears at each completion unless a read is under way outside continuous read.
// - Continuous mode cycles through enabled channels, one result each.
// - Command 01011100 enters continuous read; results shift without command.
// - Continuous read result read once; ready high until next result.
// - Unread word in continuous read is replaced at next completion.
// - Command 01011000 while ready low leaves continuous read.
// - Forty ones on data input reset everything to defaults.
// - Sync input low holds modulator and filter reset, config untouched.
// - Filter reset released on first master clock falling edge after sync.
// - Sync rising edge starts conversion; ready after full settling time.
// - Parity bit makes the transmitted ones count even.
// - Clock select picks internal, crystal or external; can drive clock out.
// - Outside continuous read each transaction starts with a command byte selecting the operation.
// - Ready goes high shortly before the result is updated.
`timescale 1ns/100ps
`default_nettype none
module acs_seq
	import acs_pkg::*;
#(
	parameter int OSC_START_CYCLES = OSC_START_CYC,
	parameter int CONV_CYCLES = 1000,
	parameter int SETTLE_CYCLES = SETTLE_PERIODS * CONV_CYCLES
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic cs_n_pin_in,
	input wire logic sclk_pin_in,
	input wire logic din_pin_in,
	input wire logic sync_n_pin_in,
	input wire logic crystal_in_pin_in,
	input wire logic crystal_out_clock_pin_in,
	input wire logic mode_write_in,
	input wire logic mode_select_bit2_in,
	input wire logic mode_select_bit1_in,
	input wire logic mode_select_bit0_in,
	input wire logic append_status_in,
	input wire logic parity_enable_in,
	input wire logic clock_source_sel_hi_in,
	input wire logic clock_source_sel_lo_in,
	input wire logic [7:0] channel_enable_in,
	input wire logic [DATA_BITS-1:0] conv_data_in,
	output logic dout_rdy_out,
	output logic dout_rdy_oe_out,
	output logic crystal_out_clock_pin_out,
	output logic crystal_out_clock_pin_oe_out,
	output logic filter_reset_out,
	output logic powered_down_out,
	output logic osc_enable_out,
	output logic cont_read_out,
	output logic status_rdy_n_out,
	output logic [2:0] chan_out,
	output logic iface_reset_out
);
	acs_pins_t pins, pins_d;
	acs_state_t state, next_state;
	acs_result_t res, next_res;
	logic [31:0] cnt, next_cnt;
	logic [2:0] chan, next_chan;
	logic rdy_n, next_rdy_n;
	logic cont_read, next_cont_read;
	logic [7:0] cmd_sr, next_cmd_sr;
	logic [2:0] cmd_cnt, next_cmd_cnt;
	logic [5:0] ones_cnt, next_ones_cnt;
	logic filt_rst, next_filt_rst;
	logic [4:0] div_cnt, next_div_cnt;
	logic int_clk, next_int_clk;
	logic mclk_d, next_mclk_d;
	logic soft_rst, next_soft_rst;
	logic next_dout, next_dout_oe, next_clk_out, next_clk_oe;
	logic sclk_rise, sclk_fall, mclk_now, mclk_fall;
	logic sh_load, sh_clear, sh_bit, sh_busy, sh_done;
	logic [WORD_BITS-1:0] sh_word;
	logic [5:0] sh_len;
	logic [2:0] mode_sel;
	logic [1:0] clk_sel;
	logic [3:0] nxt, first_ch;
	logic [7:0] cmd_byte;
	logic [7:0] status_byte;

	acs_sync #(.W(6), .RST_VAL(PINS_IDLE)) u_sync (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.async_in({cs_n_pin_in, sclk_pin_in, din_pin_in, sync_n_pin_in,
			crystal_in_pin_in, crystal_out_clock_pin_in}),
		.sync_out(pins)
	);

	acs_shifter #(.W(WORD_BITS)) u_shifter (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.load_in(sh_load),
		.clear_in(sh_clear),
		.word_in(sh_word),
		.len_in(sh_len),
		.sclk_rise_in(sclk_rise),
		.sclk_fall_in(sclk_fall),
		.bit_out(sh_bit),
		.busy_out(sh_busy),
		.done_out(sh_done)
	);

	assign mode_sel = {mode_select_bit2_in, mode_select_bit1_in, mode_select_bit0_in};
	assign clk_sel = {clock_source_sel_hi_in, clock_source_sel_lo_in};
	assign sclk_rise = pins.sclk & ~pins_d.sclk & ~pins.cs_n;
	assign sclk_fall = ~pins.sclk & pins_d.sclk & ~pins.cs_n;
	assign cmd_byte = {cmd_sr[6:0], pins.din};
	assign first_ch = acs_next_chan(channel_enable_in, 3'h7);

	// Master clock source and its falling edge
	always_comb begin
		unique case (clk_sel)
			CLKSEL_XTAL: mclk_now = pins.xtal;
			CLKSEL_EXT: mclk_now = pins.ext_clk;
			CLKSEL_INT, CLKSEL_INT_OUT: mclk_now = int_clk;
		endcase
		mclk_fall = mclk_d & ~mclk_now;
	end

	// Status byte: channel in low bits, parity above
	always_comb begin
		status_byte = {5'h0, next_res.chan};
		status_byte[STAT_PARITY_POS] = next_res.parity;
		sh_word = {next_res.data, status_byte};
		sh_len = append_status_in ? LEN_DATA_STATUS : LEN_DATA;
	end

	always_comb begin
		next_state = state;
		next_res = res;
		next_cnt = cnt;
		next_chan = chan;
		next_rdy_n = rdy_n;
		next_cont_read = cont_read;
		next_cmd_sr = cmd_sr;
		next_cmd_cnt = cmd_cnt;
		next_ones_cnt = ones_cnt;
		next_filt_rst = filt_rst;
		next_soft_rst = 1'b0;
		next_mclk_d = mclk_now;
		next_div_cnt = div_cnt + 5'h1;
		next_int_clk = int_clk;
		sh_load = 1'b0;
		sh_clear = 1'b0;
		nxt = acs_next_chan(channel_enable_in, chan);
		if (div_cnt == 5'(INT_DIV_HALF - 1)) begin
			next_div_cnt = 5'h0;
			next_int_clk = ~int_clk;
		end
		// Sync low holds filter; release on master clock fall
		if (!pins.sync_n) begin
			next_filt_rst = 1'b1;
		end else if (filt_rst && mclk_fall) begin
			next_filt_rst = 1'b0;
		end
		// Read completion raises ready
		if (sh_done) begin
			next_rdy_n = 1'b1;
		end
		// Command byte reception
		if (pins.cs_n) begin
			next_cmd_cnt = 3'h0;
		end else if (sclk_rise && (!sh_busy || cont_read)) begin
			next_cmd_sr = cmd_byte;
			next_cmd_cnt = cmd_cnt + 3'h1;
			if (cmd_cnt == 3'h7) begin
				if (cont_read) begin
					if (cmd_byte == CMD_DATA_READ && !rdy_n) begin
						next_cont_read = 1'b0;
						sh_clear = 1'b1;
					end
				end else if (cmd_byte == CMD_CONT_READ_ENTER) begin
					next_cont_read = 1'b1;
				end else if (cmd_byte == CMD_DATA_READ) begin
					sh_load = 1'b1;
				end
			end
		end
		// Conversion sequencing
		unique case (state)
			ACS_IDLE: begin
			end
			ACS_WAKE: begin
				next_cnt = cnt - 32'h1;
				if (cnt == 32'h0) begin
					next_state = ACS_CONV;
					next_chan = first_ch[2:0];
					next_cnt = 32'(SETTLE_CYCLES - 1);
					next_rdy_n = 1'b1;
				end
			end
			ACS_CONV: begin
				if (filt_rst) begin
					next_cnt = 32'(SETTLE_CYCLES - 1);
				end else begin
					next_cnt = cnt - 32'h1;
					if (cnt == 32'h1) begin
						next_rdy_n = 1'b1;
					end
					if (cnt == 32'h0) begin
						if (cont_read || !sh_busy) begin
							next_res.data = conv_data_in;
							next_res.chan = chan;
							next_res.parity = parity_enable_in & append_status_in &
								(^conv_data_in ^ ^chan);
							next_rdy_n = 1'b0;
						end
						// Result dropped when a read is under way outside continuous read
						if (mode_sel == MODE_SINGLE && nxt[3]) begin
							next_state = ACS_IDLE;
						end else begin
							next_chan = nxt[2:0];
							next_cnt = (nxt[2:0] != chan) ? 32'(SETTLE_CYCLES - 1) :
								32'(CONV_CYCLES - 1);
						end
					end
				end
			end
		endcase
		// Continuous read auto-load after completion
		if (cont_read && state == ACS_CONV && !filt_rst && cnt == 32'h0 && !sh_clear) begin
			sh_load = 1'b1;
		end
		// Mode write restarts sequencing
		if (mode_write_in) begin
			if (channel_enable_in == 8'h0) begin
				next_state = ACS_IDLE;
			end else if (mode_sel == MODE_CONT) begin
				next_state = ACS_CONV;
				next_chan = first_ch[2:0];
				next_cnt = 32'(SETTLE_CYCLES - 1);
			end else if (mode_sel == MODE_SINGLE) begin
				next_state = ACS_WAKE;
				next_cnt = 32'(OSC_START_CYCLES - 1);
			end else begin
				next_state = ACS_IDLE;
			end
		end
		// Forty consecutive ones reset everything
		if (sclk_rise) begin
			next_ones_cnt = pins.din ? ones_cnt + 6'h1 : 6'h0;
			if (pins.din && ones_cnt == 6'(ONES_FOR_RESET - 1)) begin
				next_soft_rst = 1'b1;
				next_ones_cnt = 6'h0;
				next_state = ACS_CONV;
				next_chan = 3'h0;
				next_cnt = 32'(SETTLE_CYCLES - 1);
				next_rdy_n = 1'b1;
				next_cont_read = 1'b0;
				next_cmd_cnt = 3'h0;
				next_filt_rst = 1'b0;
				next_res = '0;
				sh_clear = 1'b1;
				sh_load = 1'b0;
			end
		end
		// Pin drive
		next_dout_oe = ~pins.cs_n;
		next_dout = sh_busy ? sh_bit : rdy_n;
		next_clk_oe = (clk_sel == CLKSEL_INT_OUT);
		next_clk_out = int_clk & next_clk_oe;
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pins_d <= PINS_IDLE;
			state <= ACS_CONV;
			res <= '0;
			cnt <= 32'(SETTLE_CYCLES - 1);
			chan <= 3'h0;
			rdy_n <= 1'b1;
			cont_read <= 1'b0;
			cmd_sr <= 8'h0;
			cmd_cnt <= 3'h0;
			ones_cnt <= 6'h0;
			filt_rst <= 1'b0;
			div_cnt <= 5'h0;
			int_clk <= 1'b0;
			mclk_d <= 1'b0;
			soft_rst <= 1'b0;
			dout_rdy_out <= 1'b1;
			dout_rdy_oe_out <= 1'b0;
			crystal_out_clock_pin_out <= 1'b0;
			crystal_out_clock_pin_oe_out <= 1'b0;
		end else begin
			pins_d <= pins;
			state <= next_state;
			res <= next_res;
			cnt <= next_cnt;
			chan <= next_chan;
			rdy_n <= next_rdy_n;
			cont_read <= next_cont_read;
			cmd_sr <= next_cmd_sr;
			cmd_cnt <= next_cmd_cnt;
			ones_cnt <= next_ones_cnt;
			filt_rst <= next_filt_rst;
			div_cnt <= next_div_cnt;
			int_clk <= next_int_clk;
			mclk_d <= next_mclk_d;
			soft_rst <= next_soft_rst;
			dout_rdy_out <= next_dout;
			dout_rdy_oe_out <= next_dout_oe;
			crystal_out_clock_pin_out <= next_clk_out;
			crystal_out_clock_pin_oe_out <= next_clk_oe;
		end
	end

	// Status outputs straight from state flops
	always_comb begin
		filter_reset_out = filt_rst;
		powered_down_out = state == ACS_IDLE;
		osc_enable_out = state != ACS_IDLE;
		cont_read_out = cont_read;
		status_rdy_n_out = rdy_n;
		chan_out = chan;
		iface_reset_out = soft_rst;
	end
endmodule
`default_nettype wire

// ===== tb/acs_seq_checker.sv
// Port assertions for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module acs_seq_checker
	import acs_pkg::*;
#(
	parameter int OSC_START_CYCLES = 50,
	parameter int CONV_CYCLES = 40,
	parameter int SETTLE_CYCLES = 160
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic cs_n_pin_in,
	input wire logic sync_n_pin_in,
	input wire logic mode_write_in,
	input wire logic mode_select_bit2_in,
	input wire logic mode_select_bit1_in,
	input wire logic mode_select_bit0_in,
	input wire logic clock_source_sel_hi_in,
	input wire logic clock_source_sel_lo_in,
	input wire logic [7:0] channel_enable_in,
	input wire logic dout_rdy_oe_out,
	input wire logic crystal_out_clock_pin_out,
	input wire logic crystal_out_clock_pin_oe_out,
	input wire logic filter_reset_out,
	input wire logic powered_down_out,
	input wire logic osc_enable_out,
	input wire logic cont_read_out,
	input wire logic status_rdy_n_out,
	input wire logic iface_reset_out
);
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (!resetn_in);
	property p_oe;
		!cs_n_pin_in [*5] |-> dout_rdy_oe_out;
	endproperty
	a_oe: assert property (p_oe) else $error("ready pin undriven");
	property p_osc;
		1'b1 |-> osc_enable_out != powered_down_out;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator enable wrong");
	property p_wake;
		mode_write_in && {mode_select_bit2_in, mode_select_bit1_in, mode_select_bit0_in}
			== MODE_SINGLE && channel_enable_in != 8'h00 |=> !powered_down_out [*8];
	endproperty
	a_wake: assert property (p_wake) else $error("single mode did not wake");
	property p_filt;
		!sync_n_pin_in [*5] |-> filter_reset_out;
	endproperty
	a_filt: assert property (p_filt) else $error("filter not held");
	property p_settle;
		$fell(filter_reset_out) |=> (!$fell(status_rdy_n_out)) [*8];
	endproperty
	a_settle: assert property (p_settle) else $error("result before settling");
	property p_soft;
		iface_reset_out |=> !iface_reset_out && !cont_read_out;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset incomplete");
	property p_clkoe;
		{clock_source_sel_hi_in, clock_source_sel_lo_in} == CLKSEL_INT_OUT [*3]
			|-> crystal_out_clock_pin_oe_out;
	endproperty
	a_clkoe: assert property (p_clkoe) else $error("clock pin not driven");
	property p_clk;
		clock_source_sel_hi_in && $changed(crystal_out_clock_pin_out)
			|=> ($stable(crystal_out_clock_pin_out) || !crystal_out_clock_pin_out) [*8];
	endproperty
	a_clk: assert property (p_clk) else $error("clock out too fast");
endmodule
bind acs_seq acs_seq_checker #(.OSC_START_CYCLES(OSC_START_CYCLES),
	.CONV_CYCLES(CONV_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_acs_seq_checker (
	.clk_sys_in, .resetn_in, .cs_n_pin_in, .sync_n_pin_in, .mode_write_in,
	.mode_select_bit2_in, .mode_select_bit1_in, .mode_select_bit0_in,
	.clock_source_sel_hi_in, .clock_source_sel_lo_in, .channel_enable_in,
	.dout_rdy_oe_out, .crystal_out_clock_pin_out, .crystal_out_clock_pin_oe_out,
	.filter_reset_out, .powered_down_out, .osc_enable_out, .cont_read_out,
	.status_rdy_n_out, .iface_reset_out);
`default_nettype wire

// ===== tb/acs_host_model.sv
// Serial host model driving the converter pins
`timescale 1ns/100ps
`default_nettype none
module acs_host_model
	import acs_pkg::*;
#(
	parameter int RESET_WAIT = 200
) (
	input wire logic clk_sys_in,
	input wire logic dout_rdy_in,
	input wire logic mclk_in,
	output var acs_pins_t pins_out
);
	initial begin
		pins_out = '{cs_n: 1'b0, sclk: 1'b1, din: 1'b0, sync_n: 1'b1, xtal: 1'b0, ext_clk: 1'b0};
	end
	// One 125 ns serial clock, data taken on the rise
	task automatic clk_bit(input logic b, output logic r);
		pins_out.sclk <= 1'b0;
		pins_out.din <= b;
		repeat (12) @(posedge clk_sys_in);
		r = dout_rdy_in;
		pins_out.sclk <= 1'b1;
		repeat (13) @(posedge clk_sys_in);
	endtask
	task automatic xfer(input logic [7:0] cmd, input int ncmd, input int nrd, output logic [31:0] w);
		logic r;
		w = '0;
		for (int i = 0; i < ncmd; i++) begin
			clk_bit(cmd[7 - i], r);
		end
		for (int i = 0; i < nrd; i++) begin
			clk_bit(1'b0, r);
			w = {w[30:0], r};
		end
	endtask
	task automatic sync_low();
		pins_out.sync_n <= 1'b0;
		repeat (8) @(posedge clk_sys_in);
	endtask
	task automatic sync_release();
		@(posedge mclk_in);
		pins_out.sync_n <= 1'b1;
		@(posedge clk_sys_in);
	endtask
	task automatic soft_reset();
		logic [31:0] w;
		for (int i = 0; i < 5; i++) begin
			xfer(8'hff, 8, 0, w);
		end
		pins_out.din <= 1'b0;
		repeat (RESET_WAIT) @(posedge clk_sys_in);
	endtask
endmodule
`default_nettype wire

// ===== tb/adc_conversion_mode_sequencer_bench.sv
// Testbench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_mode_sequencer_bench
	import acs_pkg::*;
;
	localparam int SETTLE = 4000;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	acs_pins_t pins;
	logic mode_write = 1'b0;
	logic [2:0] mode = MODE_CONT;
	logic app = 1'b0;
	logic par = 1'b0;
	logic [1:0] csel = CLKSEL_INT_OUT;
	logic [7:0] chen = 8'h01;
	logic [23:0] cdata = 24'h5a0f3c;
	logic dout, dout_oe, mclk, mclk_oe, filt, pdn, osc, cread, srdy_n, irst;
	logic [2:0] chan;
	logic [31:0] w;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int rst_seen = 0;
	always #2.5 clk_sys_in = ~clk_sys_in;
	acs_seq #(.OSC_START_CYCLES(50), .CONV_CYCLES(1000), .SETTLE_CYCLES(SETTLE)) u_acs_seq (
		.clk_sys_in, .resetn_in, .cs_n_pin_in(pins.cs_n), .sclk_pin_in(pins.sclk),
		.din_pin_in(pins.din), .sync_n_pin_in(pins.sync_n), .crystal_in_pin_in(pins.xtal),
		.crystal_out_clock_pin_in(pins.ext_clk), .mode_write_in(mode_write),
		.mode_select_bit2_in(mode[2]), .mode_select_bit1_in(mode[1]),
		.mode_select_bit0_in(mode[0]), .append_status_in(app), .parity_enable_in(par),
		.clock_source_sel_hi_in(csel[1]), .clock_source_sel_lo_in(csel[0]),
		.channel_enable_in(chen), .conv_data_in(cdata), .dout_rdy_out(dout),
		.dout_rdy_oe_out(dout_oe), .crystal_out_clock_pin_out(mclk),
		.crystal_out_clock_pin_oe_out(mclk_oe), .filter_reset_out(filt),
		.powered_down_out(pdn), .osc_enable_out(osc), .cont_read_out(cread),
		.status_rdy_n_out(srdy_n), .chan_out(chan), .iface_reset_out(irst));
	acs_host_model #(.RESET_WAIT(200)) u_acs_host_model (.clk_sys_in, .dout_rdy_in(dout),
		.mclk_in(mclk), .pins_out(pins));
	task automatic end_sim();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (irst === 1'b1) rst_seen <= rst_seen + 1;
		if (cyc == 80000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_lvl(ref logic s, input logic v, input int lim);
		for (int i = 0; i < lim && s !== v; i++) @(posedge clk_sys_in);
	endtask
	task automatic set_mode(input logic [2:0] m);
		mode <= m;
		mode_write <= 1'b1;
		@(posedge clk_sys_in);
		mode_write <= 1'b0;
		@(posedge clk_sys_in);
	endtask
	task automatic t_clock();
		int n;
		logic v;
		chk(32'(mclk_oe), 32'h1);
		csel <= CLKSEL_EXT;
		repeat (3) @(posedge clk_sys_in);
		chk(32'(mclk_oe), 32'h0);
		csel <= CLKSEL_INT_OUT;
		repeat (3) @(posedge clk_sys_in);
		v = mclk;
		wait_lvl(mclk, ~v, 50);
		for (n = 0; n < 50 && mclk === ~v; n++) @(posedge clk_sys_in);
		chk(32'(n), 32'd20);
	endtask
	task automatic t_cont();
		wait_lvl(srdy_n, 1'b0, 5000);
		repeat (4) @(posedge clk_sys_in);
		chk(32'(dout), 32'h0);
		u_acs_host_model.xfer(CMD_DATA_READ, 8, 24, w);
		chk(w, 32'(cdata));
		chk(32'(srdy_n), 32'h1);
	endtask
	task automatic t_single();
		int n;
		logic [31:0] e;
		set_mode(MODE_SINGLE);
		chk(32'(pdn), 32'h0);
		for (n = 0; n < 6000 && srdy_n !== 1'b0; n++) @(posedge clk_sys_in);
		chk(32'(n >= 4040 && n <= 4060), 32'h1);
		repeat (4) @(posedge clk_sys_in);
		chk(32'(pdn), 32'h1);
		chk(32'(dout), 32'h0);
		e = 32'(cdata);
		cdata <= 24'h000001;
		u_acs_host_model.xfer(CMD_DATA_READ, 8, 24, w);
		chk(w, e);
		repeat (200) @(posedge clk_sys_in);
		chk(32'(dout), 32'h1);
		u_acs_host_model.xfer(CMD_DATA_READ, 8, 24, w);
		chk(w, e);
	endtask
	task automatic t_multi();
		logic p;
		app <= 1'b1;
		par <= 1'b1;
		chen <= 8'h24;
		cdata <= 24'h800003;
		set_mode(MODE_SINGLE);
		wait_lvl(srdy_n, 1'b0, 6000);
		repeat (2) @(posedge clk_sys_in);
		chk(32'(chan), 32'h5);
		chk(32'(pdn), 32'h0);
		wait_lvl(srdy_n, 1'b1, 5000);
		chk(32'(srdy_n), 32'h1);
		wait_lvl(srdy_n, 1'b0, 50);
		repeat (4) @(posedge clk_sys_in);
		chk(32'(pdn), 32'h1);
		p = ^{24'h800003, 3'h5};
		u_acs_host_model.xfer(CMD_DATA_READ, 8, 32, w);
		chk(w, {24'h800003, 3'h0, p, 1'h0, 3'h5});
		chk(32'(^w), 32'h0);
	endtask
	task automatic t_cread();
		app <= 1'b0;
		par <= 1'b0;
		chen <= 8'h01;
		set_mode(MODE_CONT);
		u_acs_host_model.xfer(CMD_CONT_READ_ENTER, 8, 0, w);
		chk(32'(cread), 32'h1);
		wait_lvl(srdy_n, 1'b0, 6000);
		u_acs_host_model.xfer(8'h00, 0, 24, w);
		chk(w, 32'(cdata));
		chk(32'(dout), 32'h1);
		cdata <= 24'hc30f55;
		wait_lvl(srdy_n, 1'b0, 1200);
		u_acs_host_model.xfer(8'h00, 0, 8, w);
		wait_lvl(srdy_n, 1'b1, 1200);
		wait_lvl(srdy_n, 1'b0, 50);
		u_acs_host_model.xfer(8'h00, 0, 24, w);
		chk(w, 32'hc30f55);
		wait_lvl(srdy_n, 1'b0, 1200);
		u_acs_host_model.xfer(CMD_DATA_READ, 8, 0, w);
		repeat (4) @(posedge clk_sys_in);
		chk(32'(cread), 32'h0);
	endtask
	task automatic t_sync();
		int n;
		u_acs_host_model.sync_low();
		chk(32'(filt), 32'h1);
		u_acs_host_model.sync_release();
		for (n = 0; n < 60 && filt !== 1'b0; n++) @(posedge clk_sys_in);
		chk(32'(n >= 15 && n <= 24), 32'h1);
		for (n = 0; n < 6000 && srdy_n !== 1'b1; n++) @(posedge clk_sys_in);
		for (; n < 6000 && srdy_n !== 1'b0; n++) @(posedge clk_sys_in);
		chk(32'(n >= SETTLE - 5 && n <= SETTLE + 5), 32'h1);
	endtask
	task automatic t_reset();
		int r0;
		u_acs_host_model.xfer(CMD_CONT_READ_ENTER, 8, 0, w);
		r0 = rst_seen;
		u_acs_host_model.soft_reset();
		chk(32'(rst_seen - r0), 32'h1);
		chk(32'(cread), 32'h0);
	endtask
	initial begin
		repeat (10) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		repeat (5) @(posedge clk_sys_in);
		t_clock();
		t_cont();
		t_single();
		t_multi();
		t_cread();
		t_sync();
		t_reset();
		end_sim();
	end
endmodule
`default_nettype wire
